/* core/timer_channel_mode_select.sv */
// Channel 1/2 mode select fields and channel 2 fast trigger path
//
// Contract
// - Fast mode: trigger edge forces compare level
// - Fast path output within three cycles
// - Slow path follows comparison, trigger after five; here slow_pipe drives nothing and the trigger never sets the reference
// - Fast enable acts only in pulse width modes
// - Selector picks output or input source
// - Selector writable only while channel disabled
// - Channel 2 fast bit 10, selector 9:8
// - Channel 1 fields mirror channel 2, reset zero
// - Clear enable lets external trigger clear reference
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_select (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_TRIGGER,
    input  wire logic        I_COMPARE_RESULT,
    input  wire logic        I_EXTERNAL_TRIGGER_FILTERED,
    input  wire logic        I_TRIGGER_SOURCE_INTERNAL,
    input  wire logic        I_TIMER_INPUT_ONE,
    input  wire logic        I_TIMER_INPUT_TWO,
    input  wire logic        I_INTERNAL_TRIGGER_CAPTURE_SOURCE,
    output logic             O_CH2_OUTPUT_REFERENCE,
    output logic             O_CH2_CAPTURE_INPUT,
    output logic             O_CH2_IS_OUTPUT,
    output logic             O_CH2_CHANNEL_ENABLE,
    output logic      [15:0] O_MODE_CTRL
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] mode_ctrl;
        logic        ch2_channel_enable;
        logic        trig_prev;
        logic [chan_mode_pkg::FAST_STAGES-1:0] fast_pipe;
        logic [chan_mode_pkg::SLOW_STAGES-1:0] slow_pipe;
        logic        forced;
        logic        ref_out;
        logic        cap_in;
        logic [31:0] rdata;
        logic        slverr;
    } state_s;

    state_s st;
    state_s next_st;

    logic        wr_access;
    logic        rd_access;
    logic        addr_ok;
    logic        trig_edge;
    logic [2:0]  ch2_mode;
    logic        pwm_mode;
    logic        fast_on;
    logic [1:0]  ch2_sel;
    logic [15:0] wmask;
    logic [15:0] wr_data;

    always_comb begin
        addr_ok = (I_PADDR == chan_mode_pkg::ADDR_MODE_CTRL)
               || (I_PADDR == chan_mode_pkg::ADDR_CHAN_CTRL)
               || (I_PADDR == chan_mode_pkg::ADDR_STATUS);
        wr_access = I_PSEL && I_PENABLE && I_PWRITE;
        rd_access = I_PSEL && I_PENABLE && !I_PWRITE;
        ch2_mode  = st.mode_ctrl[chan_mode_pkg::CH2_MODE_LSB +: 3];
        ch2_sel   = st.mode_ctrl[chan_mode_pkg::CH2_SEL_LSB +: 2];
        pwm_mode  = (ch2_mode == chan_mode_pkg::PULSE_WIDTH_MODE_ONE)
                 || (ch2_mode == chan_mode_pkg::PULSE_WIDTH_MODE_TWO);
        // Fast bit is ignored outside the two pulse width modes
        fast_on   = st.mode_ctrl[chan_mode_pkg::CH2_FAST_BIT]
                 && pwm_mode;
        trig_edge = I_TRIGGER && !st.trig_prev;
        wmask     = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
        wr_data   = I_PWDATA[15:0];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.trig_prev = I_TRIGGER;
        // Register writes
        if (wr_access && I_PADDR == chan_mode_pkg::ADDR_MODE_CTRL) begin
            next_st.mode_ctrl = (st.mode_ctrl & ~wmask)
                              | (wr_data & wmask);
            // Selector frozen while the channel is on
            if (st.ch2_channel_enable) begin
                next_st.mode_ctrl[chan_mode_pkg::CH2_SEL_LSB +: 2] =
                    ch2_sel;
            end
        end
        if (wr_access && I_PADDR == chan_mode_pkg::ADDR_CHAN_CTRL
            && I_PSTRB[0]) begin
            next_st.ch2_channel_enable =
                I_PWDATA[chan_mode_pkg::CH2_ENABLE_BIT];
        end
        // Read data and error
        next_st.rdata  = 32'h0000_0000;
        next_st.slverr = 1'b0;
        if (I_PSEL && !I_PENABLE) begin
            next_st.slverr = !addr_ok;
            if (!I_PWRITE) begin
                case (I_PADDR)
                    chan_mode_pkg::ADDR_MODE_CTRL: begin
                        next_st.rdata = {16'h0000, st.mode_ctrl};
                    end
                    chan_mode_pkg::ADDR_CHAN_CTRL: begin
                        next_st.rdata = {31'h0000_0000,
                                         st.ch2_channel_enable};
                    end
                    chan_mode_pkg::ADDR_STATUS: begin
                        next_st.rdata = {29'h0000_0000, st.forced,
                                         st.cap_in, st.ref_out};
                    end
                    default: begin
                        next_st.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end else if (I_PSEL && I_PENABLE) begin
            next_st.rdata  = st.rdata;
            next_st.slverr = st.slverr;
        end
        // Trigger delay pipelines, launched on the detecting edge
        next_st.fast_pipe = {st.fast_pipe[chan_mode_pkg::FAST_STAGES-2:0],
                             trig_edge && fast_on};
        next_st.slow_pipe = {st.slow_pipe[chan_mode_pkg::SLOW_STAGES-2:0],
                             trig_edge && !fast_on};
        // Output reference
        if (ch2_sel != chan_mode_pkg::SEL_OUTPUT) begin
            next_st.ref_out = 1'b0;
            next_st.forced  = 1'b0;
        end else if (st.mode_ctrl[chan_mode_pkg::CH2_CLEAR_BIT]
                     && I_EXTERNAL_TRIGGER_FILTERED) begin
            next_st.ref_out = 1'b0;
            next_st.forced  = 1'b0;
        end else if (st.fast_pipe[chan_mode_pkg::FAST_STAGES-1]
                     && fast_on) begin
            // Trigger acts as a match: compare level regardless
            next_st.ref_out = 1'b1;
            next_st.forced  = 1'b1;
        end else if (st.forced && fast_on) begin
            // Hold forced level until the comparison result is low
            next_st.ref_out = 1'b1;
            if (!I_COMPARE_RESULT) begin
                next_st.forced = 1'b0;
            end
        end else begin
            next_st.ref_out = I_COMPARE_RESULT;
            next_st.forced  = 1'b0;
        end
        // Capture input source
        case (ch2_sel)
            chan_mode_pkg::SEL_INPUT_TWO: begin
                next_st.cap_in = I_TIMER_INPUT_TWO;
            end
            chan_mode_pkg::SEL_INPUT_ONE: begin
                next_st.cap_in = I_TIMER_INPUT_ONE;
            end
            chan_mode_pkg::SEL_INT_TRIG: begin
                next_st.cap_in = I_INTERNAL_TRIGGER_CAPTURE_SOURCE
                              && I_TRIGGER_SOURCE_INTERNAL;
            end
            default: begin
                next_st.cap_in = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        O_PRDATA               = st.rdata;
        O_PREADY               = I_PSEL && I_PENABLE;
        O_PSLVERR              = I_PSEL && I_PENABLE && st.slverr;
        O_CH2_OUTPUT_REFERENCE = st.ref_out;
        O_CH2_CAPTURE_INPUT    = st.cap_in;
        O_CH2_IS_OUTPUT        = (ch2_sel == chan_mode_pkg::SEL_OUTPUT);
        O_CH2_CHANNEL_ENABLE   = st.ch2_channel_enable;
        O_MODE_CTRL            = st.mode_ctrl;
    end
endmodule : timer_channel_mode_select
`default_nettype wire

/* core/chan_mode_pkg.sv */
// Constants for the timer channel mode selection block
package chan_mode_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE_CTRL   = 12'h018;
    localparam logic [11:0] ADDR_CHAN_CTRL   = 12'h020;
    localparam logic [11:0] ADDR_STATUS      = 12'h024;
    localparam logic [15:0] MODE_CTRL_RESET  = 16'h0000;
    // --------------------------------------------------------------
    // Field positions in the channel pair mode control register
    // --------------------------------------------------------------
    localparam int CH1_SEL_LSB        = 0;
    localparam int CH1_FAST_BIT       = 2;
    localparam int CH1_PRELOAD_BIT    = 3;
    localparam int CH1_MODE_LSB       = 4;
    localparam int CH1_CLEAR_BIT      = 7;
    localparam int CH2_SEL_LSB        = 8;
    localparam int CH2_FAST_BIT       = 10;
    localparam int CH2_PRELOAD_BIT    = 11;
    localparam int CH2_MODE_LSB       = 12;
    localparam int CH2_CLEAR_BIT      = 15;
    // Channel control register: bit 0 channel 2 enable
    localparam int CH2_ENABLE_BIT     = 0;
    // --------------------------------------------------------------
    // Encodings
    // --------------------------------------------------------------
    localparam logic [2:0] PULSE_WIDTH_MODE_ONE = 3'h6;
    localparam logic [2:0] PULSE_WIDTH_MODE_TWO = 3'h7;
    typedef enum logic [1:0] {
        SEL_OUTPUT    = 2'b00,
        SEL_INPUT_TWO = 2'b01,
        SEL_INPUT_ONE = 2'b10,
        SEL_INT_TRIG  = 2'b11
    } dir_sel_e;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int FAST_DELAY_CYC     = 3;
    localparam int SLOW_DELAY_CYC     = 5;
    // Registered stages between sampled trigger edge and output
    localparam int FAST_STAGES        = FAST_DELAY_CYC - 1;
    localparam int SLOW_STAGES        = SLOW_DELAY_CYC - 1;
endpackage : chan_mode_pkg

/* sim/timer_channel_mode_select_chk.sv */
// Port checker for the channel mode select block
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_select_chk (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic        I_TRIGGER,
    input wire logic        I_COMPARE_RESULT,
    input wire logic        I_EXTERNAL_TRIGGER_FILTERED,
    input wire logic        I_TRIGGER_SOURCE_INTERNAL,
    input wire logic        I_TIMER_INPUT_TWO,
    input wire logic        O_CH2_OUTPUT_REFERENCE,
    input wire logic        O_CH2_CAPTURE_INPUT,
    input wire logic        O_CH2_IS_OUTPUT,
    input wire logic        O_CH2_CHANNEL_ENABLE,
    input wire logic [15:0] O_MODE_CTRL
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    logic [1:0] sel;
    logic       fast;
    logic       clr;
    assign sel  = O_MODE_CTRL[9:8];
    assign fast = O_MODE_CTRL[10] && O_MODE_CTRL[14:13] == 2'b11 && sel == 0;
    assign clr  = O_MODE_CTRL[15] && I_EXTERNAL_TRIGGER_FILTERED;
    AST_FAST: assert property (fast && !clr && $rose(I_TRIGGER)
        |-> ##[1:3] O_CH2_OUTPUT_REFERENCE) else $error("Fast ref late");
    AST_SLOW: assert property (!fast && !clr && sel == 0
        |=> O_CH2_OUTPUT_REFERENCE == $past(I_COMPARE_RESULT))
        else $error("Ref not following compare");
    AST_SEL_REF: assert property (sel != 0
        |=> !O_CH2_OUTPUT_REFERENCE) else $error("Ref high in input mode");
    AST_IS_OUT: assert property (O_CH2_IS_OUTPUT == (sel == 0))
        else $error("Direction flag wrong");
    AST_LOCK: assert property (I_PSEL && I_PENABLE && I_PWRITE
        && O_CH2_CHANNEL_ENABLE |=> $stable(sel)) else $error("Sel changed");
    AST_CLEAR: assert property (clr |=> !O_CH2_OUTPUT_REFERENCE)
        else $error("Ref not cleared");
    AST_CAP: assert property (sel == 2'b01
        |=> O_CH2_CAPTURE_INPUT == $past(I_TIMER_INPUT_TWO))
        else $error("Capture input wrong");
    AST_TRC: assert property (sel == 2'b11 && !I_TRIGGER_SOURCE_INTERNAL
        |=> !O_CH2_CAPTURE_INPUT) else $error("Capture not gated");
endmodule : timer_channel_mode_select_chk
bind timer_channel_mode_select timer_channel_mode_select_chk i_chk (.*);
`default_nettype wire

/* sim/tb_timer_channel_mode_select.sv */
// Directed testbench for the channel mode select block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_mode_select;
    localparam logic [11:0] MCR = chan_mode_pkg::ADDR_MODE_CTRL;
    localparam logic [11:0] CCR = chan_mode_pkg::ADDR_CHAN_CTRL;
    logic        clk, rst_n, psel, pen, pwr, trig, cmp, external_trigger_filtered, tsi, ti1, ti2;
    logic        internal_trigger_capture_source, er, pready, slverr, ref_o, cap, is_out, en;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic [15:0] mode;
    logic [15:0] tv [4] = '{16'h6400, 16'h7400, 16'h4400, 16'h6000};
    int          fail_count = 0;
    int          n_checks = 0;
    timer_channel_mode_select i_timer_channel_mode_select (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr),
        .I_TRIGGER(trig), .I_COMPARE_RESULT(cmp),
        .I_EXTERNAL_TRIGGER_FILTERED(external_trigger_filtered), .I_TRIGGER_SOURCE_INTERNAL(tsi),
        .I_TIMER_INPUT_ONE(ti1), .I_TIMER_INPUT_TWO(ti2),
        .I_INTERNAL_TRIGGER_CAPTURE_SOURCE(internal_trigger_capture_source),
        .O_CH2_OUTPUT_REFERENCE(ref_o), .O_CH2_CAPTURE_INPUT(cap),
        .O_CH2_IS_OUTPUT(is_out), .O_CH2_CHANNEL_ENABLE(en),
        .O_MODE_CTRL(mode));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwdata, pen} <= {1'b1, w, a, d, 1'b0};
        @(posedge clk);
        pen <= 1;
        // Wait for the edge that samples ready; no timeout here, only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = slverr;
        {psel, pen} <= 2'b00;
    endtask : apb
    // Trigger rising edge, then watch the reference for n cycles
    task automatic pulse(input int n, input logic exp);
        logic seen;
        seen = 0;
        trig <= 1;
        @(posedge clk);
        repeat (n) begin
            @(negedge clk);
            if (ref_o === 1'b1) seen = 1;
        end
        @(posedge clk);
        trig <= 0;
        chk(32'(seen), 32'(exp));
    endtask : pulse
    initial begin
        clk = 1'b0;
        forever #(chan_mode_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        close_out;
    end
    initial begin
        {rst_n, psel, pen, pwr, trig, cmp, external_trigger_filtered, tsi, ti1, ti2, internal_trigger_capture_source} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, MCR, 0);
        chk(rd, 0);
        chk(32'(is_out), 1);
        apb(1, MCR, 32'h0000_FFFF);
        apb(0, MCR, 0);
        chk(rd, 32'h0000_FFFF);
        apb(1, 12'h100, 32'h0000_FFFF);
        chk(32'(er), 1);
        apb(0, 12'h100, 0);
        chk(rd, 0);
        tsi <= 1;
        for (int s = 0; s < 4; s++) begin
            apb(1, MCR, 32'(s) << 8);
            {ti2, ti1, internal_trigger_capture_source} <= {s == 1, s == 2, s == 3};
            repeat (2) @(negedge clk);
            chk(32'(is_out), 32'(s == 0));
            if (s != 0) chk(32'(cap), 1);
        end
        @(posedge clk);
        tsi <= 0;
        repeat (2) @(negedge clk);
        chk(32'(cap), 0);
        apb(1, CCR, 1);
        apb(1, MCR, 32'h0000_0104);
        apb(0, MCR, 0);
        chk(rd, 32'h0000_0304);
        apb(0, CCR, 0);
        chk(rd, 1);
        apb(1, CCR, 0);
        for (int i = 0; i < 4; i++) begin
            apb(1, MCR, 32'(tv[i]));
            pulse(i < 2 ? 3 : 5, i < 2);
        end
        cmp <= 1;
        repeat (2) @(negedge clk);
        chk(32'(ref_o), 1);
        apb(1, MCR, 32'h0000_E000);
        external_trigger_filtered <= 1;
        repeat (2) @(negedge clk);
        chk(32'(ref_o), 0);
        apb(1, MCR, 32'h0000_6000);
        repeat (2) @(negedge clk);
        chk(32'(ref_o), 1);
        close_out;
    end
endmodule : tb_timer_channel_mode_select
`default_nettype wire
